// ### verification/dsr_link_sva.sv
`timescale 1ns/100ps
module dsr_link_sva (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic k_pos,
  input wire logic k_neg,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic q_oe,
  input wire logic echo_timing_out_pos,
  input wire logic echo_timing_out_neg
);
  // ----------------------------------------------------------------
  // Link checks, one clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // Selects away from a true rise would be silently lost by the device
  chk_rd_sel_rise: assert property (!read_port_select_n |-> k_pos && !$past(k_pos))
    else $error("read select outside a true rise");
  chk_wr_sel_rise: assert property (!write_port_select_n |-> k_pos && !$past(k_pos))
    else $error("write select outside a true rise");
  // Burst drives the read bus for exactly two words at the fixed latency
  chk_rd_burst_oe: assert property (!read_port_select_n |-> ##4 q_oe ##1 q_oe)
    else $error("read burst not driven at its slot");
  chk_oe_has_cause: assert property (q_oe |-> !$past(read_port_select_n, 4) ||
    !$past(read_port_select_n, 5))
    else $error("read bus driven without a read");
  chk_oe_two_words: assert property ($rose(q_oe) |=> q_oe)
    else $error("read burst cut short");
  // Echo pair trails the clock pair by one register stage
  chk_echo_follow: assert property (!$past(rst_i) |->
    echo_timing_out_pos == $past(k_pos) && echo_timing_out_neg == $past(k_neg))
    else $error("echo clocks do not follow the clock pair");
  chk_clock_pair: assert property (!$past(rst_i) |-> k_neg == !k_pos && k_pos != $past(k_pos))
    else $error("clock pair not complementary or stalled");
  chk_reset_idle: assert property ($past(rst_i) |->
    read_port_select_n && write_port_select_n && !q_oe)
    else $error("link not idle after reset");
endmodule // dsr_link_sva

// ### verification/test_dual_port_ddr_burst_sram.sv
`timescale 1ns/100ps
module test_dual_port_ddr_burst_sram import dsr_pkg::*; ();
  localparam int AW = DSR_AW;
  localparam int TIMEOUT = 12000;
  localparam int AW_S = 8;
  logic sys_clk;
  logic rst;
  logic rd_valid;
  logic [AW-1:0] rd_addr;
  logic rd_ready;
  logic wr_valid;
  logic [AW-1:0] wr_addr;
  logic [DSR_BW-1:0] wr_data;
  logic [3:0] wr_bws_n;
  logic wr_ready;
  logic [DSR_BW-1:0] rdata;
  logic rdata_valid;
  logic rdata_ready;
  logic dll_dis_n;
  logic imp_ref;
  logic dll_locked;
  logic imp_update;
  logic single_clk;
  logic [DSR_BW-1:0] rdata_s;
  logic rdata_valid_s;
  logic single_clk_s;
  logic [DSR_BW-1:0] exp_rd;
  logic rd_rdy_s;
  logic wr_rdy_s;
  int n_mismatch;
  int n_compared;
  int cyc;
  int n_imp;
  int last_imp;
  int imp_base;
  logic [DSR_BW-1:0] mdl [int];
  logic [DSR_BW-1:0] exp_q [$];

  // ----------------------------------------------------------------
  // Clock and the two ends
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  dsr_link_if #(.AW(AW)) i_dsr_link_if ();
  dsr_sram_dev #(.AW(AW)) i_dsr_sram_dev (.sys_clk_i(sys_clk), .rst_i(rst),
    .link(i_dsr_link_if.dev), .dll_disable_n_i(dll_dis_n), .impedance_ref_pin_i(imp_ref),
    .dll_locked_o(dll_locked), .imp_update_o(imp_update), .single_clk_o(single_clk));
  dsr_mem_ctl #(.AW(AW), .DEPTH(DSR_BUF_DEPTH), .SINGLE_CLK(1'b0)) i_dsr_mem_ctl (
    .sys_clk_i(sys_clk), .rst_i(rst), .link(i_dsr_link_if.ctl), .rd_valid_i(rd_valid),
    .rd_addr_i(rd_addr), .rd_ready_o(rd_ready), .wr_valid_i(wr_valid), .wr_addr_i(wr_addr),
    .wr_data_i(wr_data), .wr_bws_n_i(wr_bws_n), .wr_ready_o(wr_ready), .rdata_o(rdata),
    .rdata_valid_o(rdata_valid), .rdata_ready_i(rdata_ready));
  dsr_link_sva i_dsr_link_sva (.sys_clk_i(sys_clk), .rst_i(rst),
    .k_pos(i_dsr_link_if.k_pos), .k_neg(i_dsr_link_if.k_neg),
    .read_port_select_n(i_dsr_link_if.read_port_select_n),
    .write_port_select_n(i_dsr_link_if.write_port_select_n), .q_oe(i_dsr_link_if.q_oe),
    .echo_timing_out_pos(i_dsr_link_if.echo_timing_out_pos),
    .echo_timing_out_neg(i_dsr_link_if.echo_timing_out_neg));
  // Second pair strapped for single-clock mode, on a small array
  dsr_link_if #(.AW(AW_S)) i_dsr_link_if_s ();
  dsr_sram_dev #(.AW(AW_S)) i_dsr_sram_dev_s (.sys_clk_i(sys_clk), .rst_i(rst),
    .link(i_dsr_link_if_s.dev), .dll_disable_n_i(dll_dis_n), .impedance_ref_pin_i(imp_ref),
    .dll_locked_o(), .imp_update_o(), .single_clk_o(single_clk_s));
  dsr_mem_ctl #(.AW(AW_S), .DEPTH(DSR_BUF_DEPTH), .SINGLE_CLK(1'b1)) i_dsr_mem_ctl_s (
    .sys_clk_i(sys_clk), .rst_i(rst), .link(i_dsr_link_if_s.ctl), .rd_valid_i(rd_valid),
    .rd_addr_i(rd_addr[AW_S-1:0]), .rd_ready_o(), .wr_valid_i(wr_valid),
    .wr_addr_i(wr_addr[AW_S-1:0]), .wr_data_i(wr_data), .wr_bws_n_i(wr_bws_n), .wr_ready_o(),
    .rdata_o(rdata_s), .rdata_valid_o(rdata_valid_s), .rdata_ready_i(rdata_ready));

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic cmp_data(input string what, input logic [DSR_BW-1:0] exp,
                          input logic [DSR_BW-1:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  // Ready is sampled mid-cycle so the tasks see what the next edge will see
  always @(negedge sys_clk) begin
    rd_rdy_s = rd_ready;
    wr_rdy_s = wr_ready;
    if (!rst && rdata_valid === 1'b1 && rdata_ready === 1'b1) begin
      exp_rd = (exp_q.size() > 0) ? exp_q.pop_front() : 36'hF_FFFF_FFFF;
      cmp_data("read data", exp_rd, rdata);
      cmp_bit("single clock read valid", 1'b1, rdata_valid_s);
      cmp_data("single clock read data", exp_rd, rdata_s);
    end
    if (!rst && imp_update === 1'b1) begin
      if (n_imp > 0) begin
        cmp_data("impedance interval", 36'(2 * DSR_IMP_PERIOD_CYC), 36'(cyc - last_imp));
      end
      n_imp++;
      last_imp = cyc;
    end
  end

  // Cycle count doubles as the hang limit
  always @(posedge sys_clk) begin
    cyc <= rst ? 0 : cyc + 1;
    if (cyc >= TIMEOUT) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // User side tasks
  // ----------------------------------------------------------------
  function automatic logic [DSR_BW-1:0] merge(input logic [DSR_BW-1:0] old,
    input logic [DSR_BW-1:0] nw, input logic [3:0] bn);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (!bn[i]) merge[i*DSR_LANE +: DSR_LANE] = nw[i*DSR_LANE +: DSR_LANE];
    end
  endfunction

  // One edge passes first, so valid is never lowered and raised in one step
  task automatic wr(input logic [AW-1:0] a, input logic [DSR_BW-1:0] dt, input logic [3:0] bn);
    @(posedge sys_clk);
    wr_valid <= 1'b1;
    wr_addr <= a;
    wr_data <= dt;
    wr_bws_n <= bn;
    do @(posedge sys_clk); while (wr_rdy_s !== 1'b1);
    wr_valid <= 1'b0;
    mdl[int'(a)] = merge(mdl.exists(int'(a)) ? mdl[int'(a)] : 36'h0_0000_0000, dt, bn);
  endtask

  task automatic rd(input logic [AW-1:0] a);
    @(posedge sys_clk);
    rd_valid <= 1'b1;
    rd_addr <= a;
    do @(posedge sys_clk); while (rd_rdy_s !== 1'b1);
    rd_valid <= 1'b0;
    exp_q.push_back(mdl[int'(a)]);
  endtask

  task automatic drain();
    for (int i = 0; i < 40 && exp_q.size() != 0; i++) @(posedge sys_clk);
    cmp_bit("all reads returned", 1'b1, exp_q.size() == 0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    rd_valid = 1'b0;
    rd_addr = '0;
    wr_valid = 1'b0;
    wr_addr = '0;
    wr_data = '0;
    wr_bws_n = 4'hF;
    rdata_ready = 1'b1;
    dll_dis_n = 1'b1;
    imp_ref = 1'b1;
    n_mismatch = 0;
    n_compared = 0;
    n_imp = 0;
    last_imp = 0;
    cyc = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(negedge sys_clk);
    cmp_bit("single clock strap", 1'b0, single_clk);
    cmp_bit("single clock strap set", 1'b1, single_clk_s);
    cmp_bit("dll locked at start", 1'b0, dll_locked);
    cmp_bit("read bus driven at start", 1'b0, i_dsr_link_if.q_oe);
    // Distinct lanes expose word order and lane order
    for (int i = 0; i < 4; i++) wr(AW'(i), 36'h1_2345_6789 + 36'(i) * 36'h1_0101_0101, 4'h0);
    for (int i = 0; i < 4; i++) rd(AW'(i));
    drain();
    // Every lane pattern, each read straight after its write to check its merge
    for (int b = 0; b < 16; b++) begin
      wr(AW'(21'h00_0040), {4{9'(b) * 9'h025 + 9'h003}}, 4'(b));
      rd(AW'(21'h00_0040));
    end
    drain();
    // Read and write taken on the same edge, top address
    fork
      wr({AW{1'b1}}, 36'hA_BCDE_F012, 4'h0);
      rd(AW'(1));
    join
    rd({AW{1'b1}});
    drain();
    // Receiver stalls: the third read must wait for buffer room
    rdata_ready <= 1'b0;
    rd(AW'(0));
    rd(AW'(1));
    fork
      rd(AW'(2));
      begin
        repeat (20) @(posedge sys_clk);
        cmp_bit("third read held back", 1'b1, exp_q.size() == 2);
        rdata_ready <= 1'b1;
      end
    join
    drain();
    // Lock after 1024 true rises, and periodic impedance updates
    wait (cyc >= 2 * DSR_DLL_LOCK_CYC - 40);
    @(negedge sys_clk);
    cmp_bit("dll locked early", 1'b0, dll_locked);
    for (int i = 0; i < 100 && dll_locked !== 1'b1; i++) @(negedge sys_clk);
    cmp_bit("dll locked", 1'b1, dll_locked);
    wait (cyc >= 4 * DSR_IMP_PERIOD_CYC + 200);
    cmp_bit("impedance updates seen", 1'b1, n_imp >= 2);
    // Disabled loop drops lock; fixed impedance stops updates
    @(posedge sys_clk);
    dll_dis_n <= 1'b0;
    imp_ref <= 1'b0;
    repeat (4) @(negedge sys_clk);
    cmp_bit("dll off", 1'b0, dll_locked);
    imp_base = n_imp;
    @(posedge sys_clk);
    dll_dis_n <= 1'b1;
    repeat (2 * DSR_DLL_LOCK_CYC + 100) @(negedge sys_clk);
    cmp_bit("dll relocked", 1'b1, dll_locked);
    cmp_bit("no update with fixed impedance", 1'b1, n_imp == imp_base);
    final_report();
  end
endmodule // test_dual_port_ddr_burst_sram

// ### verilog/dsr_link_if.sv
`timescale 1ns/100ps
interface dsr_link_if import dsr_pkg::*; #(parameter int AW = DSR_AW);
  logic k_pos;
  logic k_neg;
  logic c_pos;
  logic c_neg;
  logic read_port_select_n;
  logic write_port_select_n;
  logic [1:0] byte_write_select_n;
  logic [AW-1:0] addr;
  logic [DSR_DW-1:0] d;
  logic [DSR_DW-1:0] q;
  logic q_oe;
  logic echo_timing_out_pos;
  logic echo_timing_out_neg;
  modport dev (
    input k_pos, k_neg, c_pos, c_neg, read_port_select_n, write_port_select_n,
    input byte_write_select_n, addr, d,
    output q, q_oe, echo_timing_out_pos, echo_timing_out_neg
  );
  modport ctl (
    output k_pos, k_neg, c_pos, c_neg, read_port_select_n, write_port_select_n,
    output byte_write_select_n, addr, d,
    input q, q_oe, echo_timing_out_pos, echo_timing_out_neg
  );
endinterface // dsr_link_if

// ### verilog/dsr_mem_ctl.sv
`timescale 1ns/100ps
module dsr_mem_ctl import dsr_pkg::*; #(
  parameter int AW = DSR_AW,
  parameter int DEPTH = DSR_BUF_DEPTH,
  parameter bit SINGLE_CLK = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  dsr_link_if.ctl link,
  input wire logic rd_valid_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic rd_ready_o,
  input wire logic wr_valid_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DSR_BW-1:0] wr_data_i,
  input wire logic [3:0] wr_bws_n_i,
  output logic wr_ready_o,
  output logic [DSR_BW-1:0] rdata_o,
  output logic rdata_valid_o,
  input wire logic rdata_ready_i
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic kp;
  logic kn;
  logic cp;
  logic cn;
  logic rps_n;
  logic wps_n;
  logic [1:0] bws_n;
  logic [AW-1:0] addr;
  logic [DSR_DW-1:0] d;
  logic [AW-1:0] wr_addr_h;
  logic [DSR_DW-1:0] wd1;
  logic [1:0] wb1;
  logic [CW-1:0] inflight;
  logic [DSR_BW-1:0] buf_mem [DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [CW-1:0] cnt;
  logic half;
  logic [DSR_DW-1:0] lo;

  // ----------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------
  // A read is taken only with room for its burst reserved, since the
  // device cannot be paused once the read is launched.
  wire issue_ph = ~kp;
  wire rd_room = ({1'b0, cnt} + {1'b0, inflight}) < (CW + 1)'(DEPTH);
  wire rd_go = rd_valid_i & rd_ready_o;
  wire wr_go = wr_valid_i & wr_ready_o;
  wire push = link.q_oe & half;
  wire pop = rdata_valid_o & rdata_ready_i;
  assign rd_ready_o = issue_ph & rd_room;
  assign wr_ready_o = issue_ph;

  // ----------------------------------------------------------------
  // Link clocks, divided from the system clock
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      kp <= 1'h0;
      kn <= 1'h1;
      cp <= SINGLE_CLK;
      cn <= 1'h1;
    end else begin
      kp <= ~kp;
      kn <= kp;
      cp <= SINGLE_CLK | ~kp;
      cn <= SINGLE_CLK | kp;
    end
  end

  // ----------------------------------------------------------------
  // Link drive: selects and read address with the true rise,
  // write address and second word with the inverted rise
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rps_n <= DSR_SEL_IDLE;
      wps_n <= DSR_SEL_IDLE;
      bws_n <= DSR_BWS_IDLE;
      addr <= '0;
      d <= '0;
      wr_addr_h <= '0;
      wd1 <= '0;
      wb1 <= DSR_BWS_IDLE;
    end else if (issue_ph) begin
      rps_n <= ~rd_go;
      wps_n <= ~wr_go;
      addr <= rd_addr_i;
      d <= wr_data_i[DSR_DW-1:0];
      bws_n <= wr_go ? wr_bws_n_i[1:0] : DSR_BWS_IDLE;
      wr_addr_h <= wr_addr_i;
      wd1 <= wr_data_i[DSR_BW-1:DSR_DW];
      wb1 <= wr_go ? wr_bws_n_i[3:2] : DSR_BWS_IDLE;
    end else begin
      rps_n <= DSR_SEL_IDLE;
      wps_n <= DSR_SEL_IDLE;
      addr <= wr_addr_h;
      d <= wd1;
      bws_n <= wb1;
    end
  end

  // ----------------------------------------------------------------
  // Read capture and return buffer
  // ----------------------------------------------------------------
  // Words pair low then high while the device drives the bus
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      half <= 1'h0;
      lo <= '0;
      inflight <= '0;
    end else begin
      if (link.q_oe) begin
        half <= ~half;
        lo <= link.q;
      end
      inflight <= inflight + CW'(rd_go) - CW'(push);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + PW'(1);
      end
      if (pop) begin
        rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + PW'(1);
      end
      cnt <= cnt + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      buf_mem[wp] <= {link.q, lo};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = buf_mem[rp];
  assign rdata_valid_o = (cnt != '0);
  assign link.k_pos = kp;
  assign link.k_neg = kn;
  assign link.c_pos = cp;
  assign link.c_neg = cn;
  assign link.read_port_select_n = rps_n;
  assign link.write_port_select_n = wps_n;
  assign link.byte_write_select_n = bws_n;
  assign link.addr = addr;
  assign link.d = d;

endmodule // dsr_mem_ctl

// ### verilog/dsr_pkg.sv
package dsr_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DSR_AW = 21;               // Burst address width
  localparam int DSR_DW = 18;               // Word width on the link
  localparam int DSR_BW = 2 * DSR_DW;       // One burst, two words
  localparam int DSR_LANE = 9;              // Bits per byte lane
  localparam int DSR_BUF_DEPTH = 2;         // Read return buffer entries
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DSR_CLK_PERIOD_NS = 10;
  localparam int DSR_DLL_STOP_NS = 30;
  localparam int DSR_DLL_STOP_CYC =
      (DSR_DLL_STOP_NS + DSR_CLK_PERIOD_NS - 1) / DSR_CLK_PERIOD_NS;
  localparam int DSR_DLL_LOCK_CYC = 1024;   // Link clock cycles to lock
  localparam int DSR_IMP_PERIOD_CYC = 1024; // Link clock cycles per update
  // ----------------------------------------------------------------
  // Reset values of link pins
  // ----------------------------------------------------------------
  localparam logic DSR_SEL_IDLE = 1'h1;     // Selects rest deselected
  localparam logic [1:0] DSR_BWS_IDLE = 2'h3;
  // Read output sequencer
  typedef enum logic [1:0] {DSR_OUT_IDLE, DSR_OUT_WORD1, DSR_OUT_TAIL} dsr_out_st_t;
endpackage

// ### verilog/dsr_sram_dev.sv
`timescale 1ns/100ps
module dsr_sram_dev import dsr_pkg::*; #(
  parameter int AW = DSR_AW
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  dsr_link_if.dev link,
  input wire logic dll_disable_n_i,
  input wire logic impedance_ref_pin_i,
  output logic dll_locked_o,
  output logic imp_update_o,
  output logic single_clk_o
);

  // ----------------------------------------------------------------
  // Byte lane merge
  // ----------------------------------------------------------------
  // Lanes 0/1 belong to word A+0, lanes 2/3 to word A+1
  function automatic logic [DSR_BW-1:0] merge_lanes(
    input logic [DSR_BW-1:0] old_w,
    input logic [DSR_BW-1:0] new_w,
    input logic [3:0] sel_n
  );
    logic [DSR_BW-1:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (!sel_n[i]) begin
        res[i*DSR_LANE +: DSR_LANE] = new_w[i*DSR_LANE +: DSR_LANE];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [DSR_BW-1:0] mem [2**AW];
  logic strap_done;
  logic single_clk;
  logic k_prev;
  logic oc_prev;
  logic ocn_prev;
  logic rd_a_v;
  logic [AW-1:0] rd_a_addr;
  logic rd_b_v;
  logic [AW-1:0] rd_b_addr;
  logic wr_pend;
  logic [DSR_DW-1:0] wd0;
  logic [1:0] wb0;
  dsr_out_st_t out_st;
  logic [DSR_DW-1:0] q_hi;
  logic [DSR_DW-1:0] q_r;
  logic q_oe_r;
  logic echo_pos;
  logic echo_neg;
  logic [1:0] stall_cnt;
  logic [10:0] lock_cnt;
  logic [9:0] imp_cnt;
  logic imp_pulse;

  // ----------------------------------------------------------------
  // Clock edge decode
  // ----------------------------------------------------------------
  // Link pins are synchronous, so edges are found by comparing with last
  wire k_rise = link.k_pos & ~k_prev;
  wire kn_rise = ~link.k_pos & k_prev;
  wire oc_pos = single_clk ? link.k_pos : link.c_pos;
  wire oc_neg = single_clk ? link.k_neg : link.c_neg;
  wire oc_rise = oc_pos & ~oc_prev;
  wire ocn_rise = oc_neg & ~ocn_prev;

  // Port selects only looked at on the positive rise
  wire rd_start = k_rise & ~link.read_port_select_n;
  wire wr_start = k_rise & ~link.write_port_select_n;

  // ----------------------------------------------------------------
  // Write commit and read fetch
  // ----------------------------------------------------------------
  wire wr_commit = kn_rise & wr_pend;
  wire [DSR_BW-1:0] wr_burst = {link.d, wd0};
  wire [3:0] wr_sel_n = {link.byte_write_select_n, wb0};
  wire [DSR_BW-1:0] wr_merged = merge_lanes(mem[link.addr], wr_burst, wr_sel_n);
  // Writes from earlier true rises are already in the array at fetch; a
  // commit on the fetch edge is a later write, so the read keeps old data
  wire [DSR_BW-1:0] rd_word = mem[rd_b_addr];
  wire fetch = ocn_rise & rd_b_v;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Caught once after reset release; never changes while running
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_done <= 1'h0;
      single_clk <= 1'h0;
    end else if (!strap_done) begin
      strap_done <= 1'h1;
      single_clk <= link.c_pos & link.c_neg;
    end
  end

  // Previous levels for edge detection; the echo pair is a registered
  // copy of whichever clock pair times the outputs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      k_prev <= 1'h0;
      oc_prev <= 1'h0;
      ocn_prev <= 1'h1; // Inverted pair idles high, so no false rise
      echo_pos <= 1'h0;
      echo_neg <= 1'h0;
    end else begin
      k_prev <= link.k_pos;
      oc_prev <= oc_pos;
      ocn_prev <= oc_neg;
      echo_pos <= oc_pos;
      echo_neg <= oc_neg;
    end
  end

  // ----------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------
  // Nothing is sampled while deselected, pending commit still finishes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend <= 1'h0;
      wd0 <= '0;
      wb0 <= DSR_BWS_IDLE;
    end else if (wr_start) begin
      wr_pend <= 1'h1;
      wd0 <= link.d;
      wb0 <= link.byte_write_select_n;
    end else if (wr_commit) begin
      wr_pend <= 1'h0;
    end
  end

  // Array write, address and second word taken on inverted rise
  always_ff @(posedge sys_clk_i) begin
    if (wr_commit) begin
      mem[link.addr] <= wr_merged;
    end
  end

  // ----------------------------------------------------------------
  // Read address pipeline
  // ----------------------------------------------------------------
  // Slot a holds the read latched at t; slot b waits for t+1 fetch.
  // The write port never touches these, so both ports run freely.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_a_v <= 1'h0;
      rd_a_addr <= '0;
      rd_b_v <= 1'h0;
      rd_b_addr <= '0;
    end else if (k_rise) begin
      rd_a_v <= rd_start;
      rd_b_v <= rd_a_v;
      rd_b_addr <= rd_a_addr;
      if (rd_start) begin
        rd_a_addr <= link.addr;
      end
    end else if (fetch) begin
      rd_b_v <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Read output sequencer
  // ----------------------------------------------------------------
  // Word A+0 on the inverted output rise, A+1 on the next true rise,
  // and the bus floats at the following inverted rise unless a new
  // burst takes it seamlessly.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_st <= DSR_OUT_IDLE;
      q_r <= '0;
      q_hi <= '0;
      q_oe_r <= 1'h0;
    end else if (fetch) begin
      q_r <= rd_word[DSR_DW-1:0];
      q_hi <= rd_word[DSR_BW-1:DSR_DW];
      q_oe_r <= 1'h1;
      out_st <= DSR_OUT_WORD1;
    end else if (oc_rise && out_st == DSR_OUT_WORD1) begin
      q_r <= q_hi;
      out_st <= DSR_OUT_TAIL;
    end else if (ocn_rise && out_st == DSR_OUT_TAIL) begin
      q_oe_r <= 1'h0;
      out_st <= DSR_OUT_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // DLL lock model
  // ----------------------------------------------------------------
  // Stall counter sees no link clock edge; three quiet cycles is 30 ns
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stall_cnt <= '0;
    end else if (link.k_pos != k_prev) begin
      stall_cnt <= '0;
    end else if (stall_cnt != 2'(DSR_DLL_STOP_CYC)) begin
      stall_cnt <= stall_cnt + 2'h1;
    end
  end

  // Lock counts stable link cycles and restarts itself after a stall
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_cnt <= '0;
    end else if (!dll_disable_n_i) begin
      lock_cnt <= '0;
    end else if (stall_cnt == 2'(DSR_DLL_STOP_CYC)) begin
      lock_cnt <= '0;
    end else if (k_rise && lock_cnt != 11'(DSR_DLL_LOCK_CYC)) begin
      lock_cnt <= lock_cnt + 11'h1;
    end
  end

  // ----------------------------------------------------------------
  // Impedance update
  // ----------------------------------------------------------------
  // Free counter of link cycles; tuning only with a resistor fitted,
  // a low reference pin means fixed minimum impedance.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      imp_cnt <= '0;
      imp_pulse <= 1'h0;
    end else begin
      imp_pulse <= 1'h0;
      if (k_rise) begin
        imp_cnt <= imp_cnt + 10'h1;
        if (imp_cnt == 10'(DSR_IMP_PERIOD_CYC - 1)) begin
          imp_pulse <= impedance_ref_pin_i;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.q = q_r;
  assign link.q_oe = q_oe_r;
  assign link.echo_timing_out_pos = echo_pos;
  assign link.echo_timing_out_neg = echo_neg;
  assign dll_locked_o = (lock_cnt == 11'(DSR_DLL_LOCK_CYC));
  assign imp_update_o = imp_pulse;
  assign single_clk_o = single_clk;

endmodule // dsr_sram_dev
